/* pkg/dtc_pkg.sv */
// Constants and carrier types for the dual timer/counter block.
// Assumes register indices sit on word addresses: byte address = index * 4.
package dtc_pkg;

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_RUNFLAG = 8'h88;
  localparam logic [7:0] IDX_MODE    = 8'h89;
  localparam logic [7:0] IDX_LOW0    = 8'h8a;
  localparam logic [7:0] IDX_LOW1    = 8'h8b;
  localparam logic [7:0] IDX_HIGH0   = 8'h8c;
  localparam logic [7:0] IDX_HIGH1   = 8'h8d;
  localparam logic [7:0] IDX_CLKCTL  = 8'h8e;
  localparam logic [7:0] IDX_AUX1    = 8'ha2;
  localparam logic [7:0] IDX_PORT1   = 8'hb3;

  // Mode register: one nibble per counter, counter one on top
  localparam int MODE_NIB_W = 4;
  localparam int MB_GATE    = 3;
  localparam int MB_FUNC    = 2;
  localparam int MB_MODE    = 0;

  // Per-counter bit bases, counter i adds its step
  localparam int RF_RUN_BASE  = 4;
  localparam int RF_FLAG_BASE = 5;
  localparam int RF_STEP      = 2;
  localparam int CKM_BASE     = 3;
  localparam int XTAL_BASE    = 4;
  localparam int TOG_BASE     = 2;

  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] BITS_RESET = 2'h0;

  // Timer prescale and low-speed crystal rate
  localparam int PRESCALE_DIV = 12;
  localparam int XTAL_HZ      = 32768;
  localparam int SYS_CLK_HZ   = 125000000;

  // Bus geometry
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_13     = 2'h0,
    MODE_16     = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT  = 2'h3
  } dtc_mode_t;

  // Configuration of one counter
  typedef struct packed {
    logic      gate;
    logic      func;
    logic      clk_mode;
    logic      xtal;
    logic      run;
    dtc_mode_t mode;
  } dtc_cfg_t;

  // Result of one counting step
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic       ovf_low;
    logic       ovf_high;
  } dtc_step_t;

endpackage

/* tb/dtc_pin_model.sv */
// Far-side model: count pins with pull-up, falling pulses, crystal clock.
// Assumes one system clock; the device drive wins whenever it is enabled.
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model (
  input  wire logic clk,        // System clock
  input  wire logic fall_zero,  // Pulse: one low dip on pin zero
  input  wire logic xtal_on,    // Run the crystal clock
  input  wire logic oe_zero,    // Device drives pin zero
  input  wire logic out_zero,   // Device level, pin zero
  input  wire logic oe_one,     // Device drives pin one
  input  wire logic out_one,    // Device level, pin one
  output logic      pin_zero,   // Resolved pin zero
  output logic      pin_one,    // Resolved pin one
  output logic      xtal        // Crystal clock level
);
  localparam int HALF = dtc_pkg::SYS_CLK_HZ / dtc_pkg::XTAL_HZ / 2;
  logic [1:0]  low_cnt = 2'h0;
  logic [11:0] xt_cnt = 12'h000;
  logic        xt_lvl = 1'b0;

  // Released pins sit at the pull-up; dip lasts three cycles so it is sampled
  assign pin_zero = oe_zero ? out_zero : (low_cnt == 2'h0);
  assign pin_one  = oe_one ? out_one : 1'b1;
  assign xtal     = xt_lvl;

  // Crystal stands still while off, so no stray edges between tests
  always @(posedge clk) begin
    if (fall_zero) low_cnt <= 2'h3;
    else if (low_cnt != 2'h0) low_cnt <= low_cnt - 2'h1;
    if (!xtal_on) xt_cnt <= 12'h000;
    else if (xt_cnt == 12'(HALF - 1)) xt_cnt <= 12'h000;
    else xt_cnt <= xt_cnt + 12'h001;
    if (xtal_on && xt_cnt == 12'(HALF - 1)) xt_lvl <= ~xt_lvl;
  end
endmodule
`default_nettype wire

/* tb/dtc_top_monitor.sv */
// Port checker for the dual timer/counter: bus handshake, flag and toggle pin.
// Assumes it is bound to dtc_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module dtc_top_monitor (
  input wire logic                        CLOCK,              // System clock
  input wire logic                        RST,                // Synchronous reset
  input wire logic                        WB_CYC_I,           // Bus cycle
  input wire logic                        WB_STB_I,           // Bus strobe
  input wire logic                        WB_WE_I,            // Write enable
  input wire logic [dtc_pkg::ADR_W-1:0]   WB_ADR_I,           // Byte address
  input wire logic [3:0]                  WB_SEL_I,           // Byte lanes
  input wire logic [dtc_pkg::DAT_W-1:0]   WB_DAT_I,           // Write data
  input wire logic [dtc_pkg::DAT_W-1:0]   WB_DAT_O,           // Read data
  input wire logic                        WB_ACK_O,           // Acknowledge
  input wire logic                        ISR_ENTER_ZERO,     // Service entry zero
  input wire logic                        COUNT_PIN_ZERO_O,   // Toggle output zero
  input wire logic                        COUNT_PIN_ZERO_OE,  // Drive enable zero
  input wire logic                        OVERFLOW_FLAG_ZERO  // Overflow flag zero
);
  // Request decode as the slave sees it
  wire logic       take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire logic       wr   = take & WB_WE_I & WB_SEL_I[0];
  wire logic [7:0] idx  = WB_ADR_I[9:2];
  wire logic       wr_rf = wr & (idx == dtc_pkg::IDX_RUNFLAG);
  logic [7:0]      mode_copy;
  logic            rd_mode;

  // Shadow of the mode register, so readback is judged without the design
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mode_copy <= dtc_pkg::MODE_RESET;
      rd_mode   <= 1'b0;
    end else begin
      rd_mode <= take & ~WB_WE_I & (idx == dtc_pkg::IDX_MODE);
      if (wr & (idx == dtc_pkg::IDX_MODE)) begin
        mode_copy <= WB_DAT_I[7:0];
      end
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  AST_ACK_ANSWER: assert property (take |=> WB_ACK_O)
    else $error("bus request not acked next cycle");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(WB_ACK_O) |-> $past(take))
    else $error("ack without request");
  AST_DAT_UPPER: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_MODE_READ: assert property (rd_mode |-> WB_DAT_O[7:0] == mode_copy)
    else $error("mode register readback wrong");
  AST_FLAG_SWSET: assert property (wr_rf && WB_DAT_I[5] |=> OVERFLOW_FLAG_ZERO)
    else $error("software set of flag zero lost");
  AST_FLAG_HOLD: assert property (OVERFLOW_FLAG_ZERO && !ISR_ENTER_ZERO && !wr_rf
    |=> OVERFLOW_FLAG_ZERO)
    else $error("flag zero dropped without cause");
  AST_OE_FOLLOW: assert property (wr && idx == dtc_pkg::IDX_PORT1
    |=> COUNT_PIN_ZERO_OE == $past(WB_DAT_I[2]))
    else $error("drive enable zero does not follow its bit");
  AST_TOG_IDLE: assert property (!COUNT_PIN_ZERO_OE [*2] |-> COUNT_PIN_ZERO_O)
    else $error("toggle output zero not high while idle");
  AST_TOG_OVF: assert property ($changed(COUNT_PIN_ZERO_O) && $past(COUNT_PIN_ZERO_OE)
    && COUNT_PIN_ZERO_OE |-> OVERFLOW_FLAG_ZERO)
    else $error("toggle output zero moved without overflow");
endmodule

bind dtc_top dtc_top_monitor i_dtc_top_monitor (.CLOCK(CLOCK), .RST(RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .ISR_ENTER_ZERO(ISR_ENTER_ZERO), .COUNT_PIN_ZERO_O(COUNT_PIN_ZERO_O),
  .COUNT_PIN_ZERO_OE(COUNT_PIN_ZERO_OE), .OVERFLOW_FLAG_ZERO(OVERFLOW_FLAG_ZERO));
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the dual timer/counter over classic Wishbone.
// Assumes dtc_top, the pin model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] dat_o;
  logic        ack;
  logic [1:0]  gate = 2'h0;
  logic [1:0]  isr = 2'h0;
  logic        fall0 = 1'b0;
  logic        xtal_on = 1'b0;
  logic        pin0, pin1, xtal, o0, oe0, o1, oe1, f0, f1;
  int          errors = 0;
  int          compares = 0;

  // Clock at 125 MHz
  always #4 clock = ~clock;

  dtc_top i_dtc_top (.CLOCK(clock), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .COUNT_PIN_ZERO_I(pin0), .COUNT_PIN_ONE_I(pin1), .GATE_PIN_ZERO(gate[0]),
    .GATE_PIN_ONE(gate[1]), .LOW_SPEED_CRYSTAL(xtal), .ISR_ENTER_ZERO(isr[0]),
    .ISR_ENTER_ONE(isr[1]), .COUNT_PIN_ZERO_O(o0), .COUNT_PIN_ZERO_OE(oe0),
    .COUNT_PIN_ONE_O(o1), .COUNT_PIN_ONE_OE(oe1), .OVERFLOW_FLAG_ZERO(f0),
    .OVERFLOW_FLAG_ONE(f1));
  dtc_pin_model i_dtc_pin_model (.clk(clock), .fall_zero(fall0), .xtal_on(xtal_on),
    .oe_zero(oe0), .out_zero(o0), .oe_one(oe1), .out_one(o1), .pin_zero(pin0),
    .pin_one(pin1), .xtal(xtal));

  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle, held until ack is sampled; no latency assumed,
  // a hung slave is caught by the watchdog alone
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hf;
    dat <= {24'h000000, d};
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    wb(1'b0, idx, 8'h00, q);
  endtask

  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    rd(idx, q);
    check(what, q, exp);
  endtask

  // Stop both counters first, then load mode, clock select and bytes
  task automatic cfg(input logic [7:0] m, ck, l0, h0, l1, h1);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h00);
    wr(dtc_pkg::IDX_MODE, m);
    wr(dtc_pkg::IDX_CLKCTL, ck);
    wr(dtc_pkg::IDX_LOW0, l0);
    wr(dtc_pkg::IDX_HIGH0, h0);
    wr(dtc_pkg::IDX_LOW1, l1);
    wr(dtc_pkg::IDX_HIGH1, h1);
  endtask

  task automatic pulse_isr(input logic [1:0] v);
    isr <= v;
    @(posedge clock);
    isr <= 2'h0;
    @(posedge clock);
  endtask

  task automatic falls(input int n);
    repeat (n) begin
      fall0 <= 1'b1;
      @(posedge clock);
      fall0 <= 1'b0;
      repeat (6) @(posedge clock);
    end
  endtask

  task automatic print_verdict();
    $display("TB counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well above the crystal test, the longest one
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    print_verdict();
  end

  initial begin
    logic [7:0] q;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    check("flag zero", 8'(f0), 8'h00);
    check("toggle out", 8'(o0), 8'h01);
    check("drive enable", 8'(oe0), 8'h00);
    rchk("mode", dtc_pkg::IDX_MODE, dtc_pkg::MODE_RESET);
    wr(dtc_pkg::IDX_MODE, 8'ha5);
    rchk("mode", dtc_pkg::IDX_MODE, 8'ha5);
    rchk("unmapped", 8'h90, 8'h00);
    $display("TB test registers done");
    cfg(8'h01, 8'h08, 8'hfd, 8'hff, 8'h00, 8'h00);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h10);
    repeat (10) @(posedge clock);
    check("flag zero", 8'(f0), 8'h01);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h20);
    pulse_isr(2'h1);
    check("flag zero", 8'(f0), 8'h00);
    rchk("high0", dtc_pkg::IDX_HIGH0, 8'h00);
    wr(dtc_pkg::IDX_LOW0, 8'h42);
    repeat (20) @(posedge clock);
    rchk("low0 held", dtc_pkg::IDX_LOW0, 8'h42);
    $display("TB test sixteen done");
    cfg(8'h00, 8'h08, 8'hff, 8'hff, 8'h00, 8'h00);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h10);
    repeat (8) @(posedge clock);
    check("flag zero", 8'(f0), 8'h01);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h00);
    rd(dtc_pkg::IDX_LOW0, q);
    check("low0 top", {5'h00, q[7:5]}, 8'h07);
    rchk("high0", dtc_pkg::IDX_HIGH0, 8'h00);
    $display("TB test thirteen done");
    cfg(8'h20, 8'h10, 8'h00, 8'h00, 8'hf0, 8'hf0);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h40);
    repeat (40) @(posedge clock);
    check("flag one", 8'(f1), 8'h01);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h80);
    pulse_isr(2'h2);
    check("flag one", 8'(f1), 8'h00);
    rchk("high1", dtc_pkg::IDX_HIGH1, 8'hf0);
    rd(dtc_pkg::IDX_LOW1, q);
    check("low1 floor", 8'(q >= 8'hf0), 8'h01);
    $display("TB test reload done");
    cfg(8'h30, 8'h10, 8'h00, 8'h00, 8'h55, 8'h00);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h40);
    repeat (20) @(posedge clock);
    rchk("low1 halted", dtc_pkg::IDX_LOW1, 8'h55);
    $display("TB test halt done");
    cfg(8'h33, 8'h08, 8'h00, 8'hfe, 8'h00, 8'h00);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h40);
    repeat (20) @(posedge clock);
    check("flag one", 8'(f1), 8'h01);
    check("flag zero", 8'(f0), 8'h00);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h00);
    rchk("low0 split", dtc_pkg::IDX_LOW0, 8'h00);
    $display("TB test split done");
    cfg(8'h05, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h10);
    falls(3);
    wr(dtc_pkg::IDX_MODE, 8'h0d);
    falls(2);
    gate[0] <= 1'b1;
    falls(2);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h00);
    rchk("low0 edges", dtc_pkg::IDX_LOW0, 8'h05);
    $display("TB test pin count done");
    cfg(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h10);
    repeat (240) @(posedge clock);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h00);
    rd(dtc_pkg::IDX_LOW0, q);
    check("low0 prescaled", 8'(q >= 8'd20 && q <= 8'd21), 8'h01);
    $display("TB test prescale done");
    wr(dtc_pkg::IDX_PORT1, 8'h0c);
    cfg(8'h11, 8'h18, 8'hfd, 8'hff, 8'hfd, 8'hff);
    check("drive enable", 8'(oe0), 8'h01);
    check("drive enable one", 8'(oe1), 8'h01);
    check("toggle out", 8'(o0), 8'h01);
    check("toggle out one", 8'(o1), 8'h01);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h50);
    repeat (10) @(posedge clock);
    check("toggle out", 8'(o0), 8'h00);
    check("toggle out one", 8'(o1), 8'h00);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h00);
    wr(dtc_pkg::IDX_PORT1, 8'h00);
    $display("TB test toggle done");
    wr(dtc_pkg::IDX_AUX1, 8'h10);
    cfg(8'h01, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00);
    xtal_on <= 1'b1;
    wr(dtc_pkg::IDX_RUNFLAG, 8'h10);
    repeat (15300) @(posedge clock);
    wr(dtc_pkg::IDX_RUNFLAG, 8'h00);
    xtal_on <= 1'b0;
    rd(dtc_pkg::IDX_LOW0, q);
    check("low0 crystal", 8'(q >= 8'd3 && q <= 8'd4), 8'h01);
    $display("TB test crystal done");
    print_verdict();
  end
endmodule
`default_nettype wire

/* verilog/dtc_edge.sv */
// Edge detector on a sampled pin, one-cycle pulse per edge.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module dtc_edge #(
  parameter bit FALL = 1'b1  // 1 detects high-to-low, 0 low-to-high
) (
  input  wire logic clk,    // System clock
  input  wire logic rst,    // Synchronous reset, active high
  input  wire logic pin,    // Sampled pin level
  output logic      pulse   // One-cycle edge pulse
);
  logic prev;

  // Reset value chosen so no false edge follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= ~FALL;
    end else begin
      prev <= pin;
    end
  end

  // High one cycle, then low the next
  assign pulse = FALL ? (prev & ~pin) : (~prev & pin);
endmodule
`default_nettype wire

/* verilog/dtc_prescale.sv */
// Free-running divider giving one tick every DIV system clocks.
// Assumes one clock and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module dtc_prescale #(
  parameter int DIV = dtc_pkg::PRESCALE_DIV  // Clocks per tick
) (
  input  wire logic clk,   // System clock
  input  wire logic rst,   // Synchronous reset, active high
  output logic      tick   // One-cycle tick
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt;

  // Wraps at DIV-1, tick on the last count
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= (cnt == LAST) ? '0 : cnt + W'(1);
    end
  end

  assign tick = (cnt == LAST);
endmodule
`default_nettype wire

/* verilog/dtc_top.sv */
// Dual 16-bit timer/counter with Wishbone classic register access.
// Assumes pins are synchronous to CLOCK and a single-master bus.
`timescale 1ns/100ps
`default_nettype none
module dtc_top (
  input  wire logic                    CLOCK,               // System clock, 125 MHz
  input  wire logic                    RST,                 // Synchronous reset, high
  input  wire logic                    WB_CYC_I,            // Bus cycle
  input  wire logic                    WB_STB_I,            // Bus strobe
  input  wire logic                    WB_WE_I,             // Write enable
  input  wire logic [dtc_pkg::ADR_W-1:0] WB_ADR_I,          // Byte address
  input  wire logic [3:0]              WB_SEL_I,            // Byte lanes
  input  wire logic [dtc_pkg::DAT_W-1:0] WB_DAT_I,          // Write data
  output logic      [dtc_pkg::DAT_W-1:0] WB_DAT_O,          // Read data
  output logic                         WB_ACK_O,            // Acknowledge
  input  wire logic                    COUNT_PIN_ZERO_I,    // Count pin zero level
  input  wire logic                    COUNT_PIN_ONE_I,     // Count pin one level
  input  wire logic                    GATE_PIN_ZERO,       // Gate pin zero level
  input  wire logic                    GATE_PIN_ONE,        // Gate pin one level
  input  wire logic                    LOW_SPEED_CRYSTAL,   // Crystal clock, sampled
  input  wire logic                    ISR_ENTER_ZERO,      // Service entry, counter zero
  input  wire logic                    ISR_ENTER_ONE,       // Service entry, counter one
  output logic                         COUNT_PIN_ZERO_O,    // Toggle output zero
  output logic                         COUNT_PIN_ZERO_OE,   // Toggle drive enable zero
  output logic                         COUNT_PIN_ONE_O,     // Toggle output one
  output logic                         COUNT_PIN_ONE_OE,    // Toggle drive enable one
  output logic                         OVERFLOW_FLAG_ZERO,  // Overflow flag zero
  output logic                         OVERFLOW_FLAG_ONE    // Overflow flag one
);

  // Software-visible state
  logic [7:0] timer_mode_config;
  logic [1:0] run;
  logic [1:0] flag;
  logic [1:0] clk_mode;
  logic [1:0] xtal;
  logic [1:0] tog_en;
  logic [1:0] tog_pin;
  logic [7:0] high [2];
  logic [7:0] low  [2];
  logic       ack;
  logic [7:0] rd_q;

  // One counting step for any mode
  function automatic dtc_pkg::dtc_step_t step(
    input dtc_pkg::dtc_mode_t mode,
    input logic [7:0]         h,
    input logic [7:0]         l,
    input logic               inc_low,
    input logic               inc_high
  );
    dtc_pkg::dtc_step_t r;
    logic [12:0] v13;
    logic [15:0] v16;
    r.high     = h;
    r.low      = l;
    r.ovf_low  = 1'b0;
    r.ovf_high = 1'b0;
    v13 = {h, l[4:0]} + 13'h0001;
    v16 = {h, l} + 16'h0001;
    unique case (mode)
      dtc_pkg::MODE_13: begin
        if (inc_low) begin
          r.high    = v13[12:5];
          r.low     = {l[7:5], v13[4:0]};
          r.ovf_low = (v13 == 13'h0000);
        end
      end
      dtc_pkg::MODE_16: begin
        if (inc_low) begin
          r.high    = v16[15:8];
          r.low     = v16[7:0];
          r.ovf_low = (v16 == 16'h0000);
        end
      end
      dtc_pkg::MODE_RELOAD: begin
        if (inc_low) begin
          r.ovf_low = (l == 8'hff);
          r.low     = r.ovf_low ? h : l + 8'h01;
        end
      end
      dtc_pkg::MODE_SPLIT: begin
        if (inc_low) begin
          r.low     = l + 8'h01;
          r.ovf_low = (l == 8'hff);
        end
        if (inc_high) begin
          r.high     = h + 8'h01;
          r.ovf_high = (h == 8'hff);
        end
      end
    endcase
    return r;
  endfunction

  // Bus decode
  wire       req     = WB_CYC_I & WB_STB_I & ~ack;
  wire       wr      = req & WB_WE_I & WB_SEL_I[0];
  wire [7:0] idx     = WB_ADR_I[dtc_pkg::ADR_W-1:2];
  wire [7:0] wdat    = WB_DAT_I[7:0];
  wire       wr_rf   = wr & (idx == dtc_pkg::IDX_RUNFLAG);
  wire       wr_mode = wr & (idx == dtc_pkg::IDX_MODE);
  wire       wr_ckc  = wr & (idx == dtc_pkg::IDX_CLKCTL);
  wire       wr_aux  = wr & (idx == dtc_pkg::IDX_AUX1);
  wire       wr_port = wr & (idx == dtc_pkg::IDX_PORT1);
  wire [1:0] wr_low  = {wr & (idx == dtc_pkg::IDX_LOW1),
                        wr & (idx == dtc_pkg::IDX_LOW0)};
  wire [1:0] wr_high = {wr & (idx == dtc_pkg::IDX_HIGH1),
                        wr & (idx == dtc_pkg::IDX_HIGH0)};

  // Shared clock sources
  logic       div_tick;
  logic       xtal_tick;
  logic [1:0] pin_fall;

  dtc_prescale #(
    .DIV (dtc_pkg::PRESCALE_DIV)
  ) u_prescale (
    .clk  (CLOCK),
    .rst  (RST),
    .tick (div_tick)
  );

  // Crystal counted on its rising edge, sampled by the system clock
  dtc_edge #(
    .FALL (1'b0)
  ) u_xtal_edge (
    .clk   (CLOCK),
    .rst   (RST),
    .pin   (LOW_SPEED_CRYSTAL),
    .pulse (xtal_tick)
  );

  // Per-counter configuration and sources
  wire [1:0]          count_pin = {COUNT_PIN_ONE_I, COUNT_PIN_ZERO_I};
  wire [1:0]          gate_pin  = {GATE_PIN_ONE, GATE_PIN_ZERO};
  dtc_pkg::dtc_cfg_t  cfg      [2];
  logic [1:0]         clk_tick;
  logic [1:0]         src_tick;
  logic [1:0]         enable;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_src
      localparam int NB = g * dtc_pkg::MODE_NIB_W;

      // Falling edges of the count pin, high then low
      dtc_edge #(
        .FALL (1'b1)
      ) u_pin_edge (
        .clk   (CLOCK),
        .rst   (RST),
        .pin   (count_pin[g]),
        .pulse (pin_fall[g])
      );

      assign cfg[g].gate     = timer_mode_config[NB + dtc_pkg::MB_GATE];
      assign cfg[g].func     = timer_mode_config[NB + dtc_pkg::MB_FUNC];
      assign cfg[g].mode     = dtc_pkg::dtc_mode_t'(
                                 timer_mode_config[NB + dtc_pkg::MB_MODE +: 2]);
      assign cfg[g].clk_mode = clk_mode[g];
      assign cfg[g].xtal     = xtal[g];
      assign cfg[g].run      = run[g];

      // Crystal overrides; otherwise clock/12 or full clock
      assign clk_tick[g] = cfg[g].xtal ? xtal_tick :
                           (cfg[g].clk_mode ? 1'b1 : div_tick);
      assign src_tick[g] = (cfg[g].func & ~cfg[g].xtal) ? pin_fall[g]
                                                         : clk_tick[g];
      // Gate only restricts, never starts a stopped counter
      assign enable[g]   = cfg[g].run & (~cfg[g].gate | gate_pin[g]);
    end
  endgenerate

  // Counting steps
  wire split0   = (cfg[0].mode == dtc_pkg::MODE_SPLIT);
  wire halt1    = (cfg[1].mode == dtc_pkg::MODE_SPLIT);
  wire inc_l0   = enable[0] & src_tick[0];
  wire inc_h0   = split0 & run[1] & clk_tick[0];
  wire inc_l1   = enable[1] & src_tick[1] & ~halt1;

  dtc_pkg::dtc_step_t upd [2];
  assign upd[0] = step(cfg[0].mode, high[0], low[0], inc_l0, inc_h0);
  assign upd[1] = step(cfg[1].mode, high[1], low[1], inc_l1, 1'b0);

  // Overflow events; split high byte reports through flag one
  wire [1:0] ovf_evt = {split0 ? upd[0].ovf_high : upd[1].ovf_low,
                        upd[0].ovf_low};
  wire [1:0] isr     = {ISR_ENTER_ONE, ISR_ENTER_ZERO};

  // Byte registers; a bus write beats a step in the same cycle
  generate
    for (g = 0; g < 2; g++) begin : gen_cnt
      always_ff @(posedge CLOCK) begin
        if (RST) begin
          low[g]  <= dtc_pkg::BYTE_RESET;
          high[g] <= dtc_pkg::BYTE_RESET;
        end else begin
          low[g]  <= wr_low[g]  ? wdat : upd[g].low;
          high[g] <= wr_high[g] ? wdat : upd[g].high;
        end
      end
    end
  endgenerate

  // Control bits, run and flag; overflow wins over any clear
  logic [1:0] next_run;
  logic [1:0] next_flag;
  generate
    for (g = 0; g < 2; g++) begin : gen_ctl
      localparam int RB = dtc_pkg::RF_RUN_BASE + g * dtc_pkg::RF_STEP;
      localparam int FB = dtc_pkg::RF_FLAG_BASE + g * dtc_pkg::RF_STEP;
      assign next_run[g]  = wr_rf ? wdat[RB] : run[g];
      assign next_flag[g] = ovf_evt[g] |
                            (wr_rf ? wdat[FB] : (flag[g] & ~isr[g]));
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      run  <= dtc_pkg::BITS_RESET;
      flag <= dtc_pkg::BITS_RESET;
    end else begin
      run  <= next_run;
      flag <= next_flag;
    end
  end

  // Configuration registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      timer_mode_config <= dtc_pkg::MODE_RESET;
      clk_mode          <= dtc_pkg::BITS_RESET;
      xtal              <= dtc_pkg::BITS_RESET;
      tog_en            <= dtc_pkg::BITS_RESET;
    end else begin
      if (wr_mode) timer_mode_config <= wdat;
      if (wr_ckc)  clk_mode <= wdat[dtc_pkg::CKM_BASE +: 2];
      if (wr_aux)  xtal     <= wdat[dtc_pkg::XTAL_BASE +: 2];
      if (wr_port) tog_en   <= wdat[dtc_pkg::TOG_BASE +: 2];
    end
  end

  // Toggle pins: parked at 1 while off, so the first overflow drives 0
  generate
    for (g = 0; g < 2; g++) begin : gen_tog
      always_ff @(posedge CLOCK) begin
        if (RST) begin
          tog_pin[g] <= 1'b1;
        end else if (!tog_en[g]) begin
          tog_pin[g] <= 1'b1;
        end else if (g == 0 ? upd[0].ovf_low : upd[1].ovf_low) begin
          tog_pin[g] <= ~tog_pin[g];
        end
      end
    end
  endgenerate

  // Read selection; unmapped indices read zero
  wire [7:0] rf_rd   = {flag[1], run[1], flag[0], run[0], 4'h0};
  wire [7:0] ckc_rd  = {3'h0, clk_mode, 3'h0};
  wire [7:0] aux_rd  = {2'h0, xtal, 4'h0};
  wire [7:0] port_rd = {4'h0, tog_en, 2'h0};
  wire [7:0] rd_sel  =
    (idx == dtc_pkg::IDX_RUNFLAG) ? rf_rd             :
    (idx == dtc_pkg::IDX_MODE)    ? timer_mode_config :
    (idx == dtc_pkg::IDX_LOW0)    ? low[0]            :
    (idx == dtc_pkg::IDX_LOW1)    ? low[1]            :
    (idx == dtc_pkg::IDX_HIGH0)   ? high[0]           :
    (idx == dtc_pkg::IDX_HIGH1)   ? high[1]           :
    (idx == dtc_pkg::IDX_CLKCTL)  ? ckc_rd            :
    (idx == dtc_pkg::IDX_AUX1)    ? aux_rd            :
    (idx == dtc_pkg::IDX_PORT1)   ? port_rd           : 8'h00;

  // One-wait-state answer; ack drops the cycle after it is given
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ack  <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      ack  <= req;
      rd_q <= req ? rd_sel : rd_q;
    end
  end

  // Outputs straight from flip-flops
  assign WB_ACK_O           = ack;
  assign WB_DAT_O           = {24'h000000, rd_q};
  assign COUNT_PIN_ZERO_O   = tog_pin[0];
  assign COUNT_PIN_ONE_O    = tog_pin[1];
  assign COUNT_PIN_ZERO_OE  = tog_en[0];
  assign COUNT_PIN_ONE_OE   = tog_en[1];
  assign OVERFLOW_FLAG_ZERO = flag[0];
  assign OVERFLOW_FLAG_ONE  = flag[1];

endmodule
`default_nettype wire
